// ---- logic/sssl_consts.vh ----
`ifndef SSSL_CONSTS_VH
`define SSSL_CONSTS_VH

// register and fifo sizes
`define SSSL_WIDTH        8
`define SSSL_FIFO_DEPTH   8
`define SSSL_FIFO_AW      3
// fifo entry layout: {store, shift, data}
`define SSSL_EV_WIDTH     3
`define SSSL_EV_STORE     2
`define SSSL_EV_SHIFT     1
`define SSSL_EV_DATA      0
// pin sampling
`define SSSL_PIN_COUNT    5
`define SSSL_PIN_DATA     0
`define SSSL_PIN_SHCLK    1
`define SSSL_PIN_STCLK    2
`define SSSL_PIN_MRST_N   3
`define SSSL_PIN_OE_N     4
// reset values
`define SSSL_SHIFT_RST    8'h00
`define SSSL_STORE_RST    8'h00
`define SSSL_PIN_RST      5'h18

`endif

// ---- logic/sssl_fifo.v ----
`timescale 1ns/100ps
module sssl_fifo #(
  parameter W     = 3,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire          core_clk_i,
  input  wire          rst_n_i,
  input  wire          flush_i,
  // fill side
  input  wire          in_valid_i,
  output wire          in_ready_o,
  input  wire [W-1:0]  in_data_i,
  // drain side
  output wire          out_valid_o,
  input  wire          out_ready_i,
  output wire [W-1:0]  out_data_o
);
  localparam [AW:0] FULL_CNT = DEPTH[AW:0];

  reg  [W-1:0]  mem_ff [0:DEPTH-1];
  reg  [AW-1:0] wr_ptr_ff;
  reg  [AW-1:0] rd_ptr_ff;
  reg  [AW:0]   cnt_ff;
  wire          push;
  wire          pop;

  assign in_ready_o  = (cnt_ff != FULL_CNT);
  assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
  assign out_data_o  = mem_ff[rd_ptr_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge core_clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i || flush_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff    <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// ---- logic/sssl_top.v ----
// Contract
// - eight-stage shift register and eight-bit storage register, each on its own clock
// - shift clock rising edge shifts by one, serial data into first stage
// - storage clock rising edge copies all eight shift bits into storage
// - shift clock rising edge updates cascade output with last stage
// - low master reset clears shift and storage registers regardless of clocks
// - common clocks: storage holds shift contents from one pulse earlier
// - enable low: set storage bit turns its output transistor on, pulling low
// - enable high: all eight outputs off, whatever storage holds
// - output enable changes never alter shift or storage contents
`timescale 1ns/100ps
`include "sssl_consts.vh"
module sssl_top (
  // clock and reset
  input  wire                   core_clk_i,
  input  wire                   rst_n_i,
  // serial link pins
  input  wire                   serial_data_in_i,
  input  wire                   shift_clock_i,
  input  wire                   storage_clock_i,
  input  wire                   master_reset_n_i,
  input  wire                   out_enable_n_i,
  output wire                   cascade_serial_out_o,
  // open-drain parallel outputs
  output wire [`SSSL_WIDTH-1:0] parallel_drive_out_o,
  output wire [`SSSL_WIDTH-1:0] parallel_drive_oe_o,
  // event buffer status
  output wire                   event_ready_o
);
  reg  [`SSSL_PIN_COUNT-1:0] pin_meta_ff;
  reg  [`SSSL_PIN_COUNT-1:0] pin_sync_ff;
  reg                        shclk_prev_ff;
  reg                        stclk_prev_ff;
  reg  [`SSSL_WIDTH-1:0]     shift_ff;
  reg  [`SSSL_WIDTH-1:0]     store_ff;
  reg  [`SSSL_WIDTH-1:0]     nxt_shift;
  reg  [`SSSL_WIDTH-1:0]     nxt_store;
  reg                        cascade_ff;
  reg  [`SSSL_WIDTH-1:0]     drv_oe_ff;
  reg  [`SSSL_WIDTH-1:0]     drv_out_ff;
  reg                        ev_ready_ff;
  wire                       shclk_rise;
  wire                       stclk_rise;
  wire                       mrst_act;
  wire                       ev_valid;
  wire                       ev_in_ready;
  wire [`SSSL_EV_WIDTH-1:0]  ev_in;
  wire                       ev_out_valid;
  wire [`SSSL_EV_WIDTH-1:0]  ev_out;
  wire                       ev_pop;
  wire                       ev_do_shift;
  wire                       ev_do_store;
  wire                       ev_bit;
  genvar                     gi;

  localparam [`SSSL_PIN_COUNT-1:0] PIN_RST = `SSSL_PIN_RST;

  // raw pin behind sampler slot idx
  function pin_pick;
    input integer idx;
    input         data_pin;
    input         shclk_pin;
    input         stclk_pin;
    input         mrst_n_pin;
    input         oe_n_pin;
    begin
      case (idx)
        `SSSL_PIN_DATA:   pin_pick = data_pin;
        `SSSL_PIN_SHCLK:  pin_pick = shclk_pin;
        `SSSL_PIN_STCLK:  pin_pick = stclk_pin;
        `SSSL_PIN_MRST_N: pin_pick = mrst_n_pin;
        default:          pin_pick = oe_n_pin;
      endcase
    end
  endfunction

  // rising edge of a sampled level against its last sample
  function rise_of;
    input cur;
    input prev;
    begin
      rise_of = cur & ~prev;
    end
  endfunction

  // two-flop sampling of every pin
  generate
    for (gi = 0; gi < `SSSL_PIN_COUNT; gi = gi + 1) begin : g_sync
      always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          pin_meta_ff[gi] <= PIN_RST[gi];
          pin_sync_ff[gi] <= PIN_RST[gi];
        end else begin
          pin_meta_ff[gi] <= pin_pick(gi, serial_data_in_i, shift_clock_i, storage_clock_i,
                                      master_reset_n_i, out_enable_n_i);
          pin_sync_ff[gi] <= pin_meta_ff[gi];
        end
      end
    end
  endgenerate

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      shclk_prev_ff <= 1'b0;
      stclk_prev_ff <= 1'b0;
    end else begin
      shclk_prev_ff <= pin_sync_ff[`SSSL_PIN_SHCLK];
      stclk_prev_ff <= pin_sync_ff[`SSSL_PIN_STCLK];
    end
  end

  // each link clock detected on its own edge, independent of the other
  assign shclk_rise = rise_of(pin_sync_ff[`SSSL_PIN_SHCLK], shclk_prev_ff);
  assign stclk_rise = rise_of(pin_sync_ff[`SSSL_PIN_STCLK], stclk_prev_ff);
  assign mrst_act   = ~pin_sync_ff[`SSSL_PIN_MRST_N];

  // one entry holds both edges seen together, so a common clock keeps order
  assign ev_valid = (shclk_rise | stclk_rise) & ~mrst_act;
  assign ev_in    = {stclk_rise, shclk_rise, pin_sync_ff[`SSSL_PIN_DATA]};
  assign ev_pop   = ev_out_valid & ~mrst_act;

  sssl_fifo #(
    .W     (`SSSL_EV_WIDTH),
    .DEPTH (`SSSL_FIFO_DEPTH),
    .AW    (`SSSL_FIFO_AW)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (mrst_act),
    .in_valid_i  (ev_valid),
    .in_ready_o  (ev_in_ready),
    .in_data_i   (ev_in),
    .out_valid_o (ev_out_valid),
    .out_ready_i (~mrst_act),
    .out_data_o  (ev_out)
  );

  // entry fields, valid only while an entry is taken
  assign ev_do_shift = ev_pop & ev_out[`SSSL_EV_SHIFT];
  assign ev_do_store = ev_pop & ev_out[`SSSL_EV_STORE];
  assign ev_bit      = ev_out[`SSSL_EV_DATA];

  always @* begin
    nxt_shift = shift_ff;
    nxt_store = store_ff;
    if (ev_do_shift) begin
      nxt_shift = {shift_ff[`SSSL_WIDTH-2:0], ev_bit};
    end
    if (ev_do_store) begin
      nxt_store = shift_ff;
    end
  end

  // enable pin plays no part here
  always @(posedge core_clk_i) begin
    if (!rst_n_i || mrst_act) begin
      shift_ff <= `SSSL_SHIFT_RST;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i || mrst_act) begin
      store_ff <= `SSSL_STORE_RST;
    end else begin
      store_ff <= nxt_store;
    end
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i || mrst_act) begin
      cascade_ff <= 1'b0;
    end else begin
      cascade_ff <= nxt_shift[`SSSL_WIDTH-1];
    end
  end

  // open drain: enable carries the bit, master reset and enable pin switch it off
  generate
    for (gi = 0; gi < `SSSL_WIDTH; gi = gi + 1) begin : g_drive
      always @(posedge core_clk_i) begin
        if (!rst_n_i || mrst_act) begin
          drv_oe_ff[gi] <= 1'b0;
        end else if (pin_sync_ff[`SSSL_PIN_OE_N]) begin
          drv_oe_ff[gi] <= 1'b0;
        end else begin
          drv_oe_ff[gi] <= nxt_store[gi];
        end
      end
    end
  endgenerate

  // drive value stays low, the enable alone pulls the pin
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      drv_out_ff <= {`SSSL_WIDTH{1'b0}};
    end else begin
      drv_out_ff <= {`SSSL_WIDTH{1'b0}};
    end
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ev_ready_ff <= 1'b0;
    end else begin
      ev_ready_ff <= ev_in_ready;
    end
  end

  assign cascade_serial_out_o = cascade_ff;
  assign parallel_drive_out_o = drv_out_ff;
  assign parallel_drive_oe_o  = drv_oe_ff;
  assign event_ready_o        = ev_ready_ff;
endmodule

// ---- bench/sssl_top_assertions.sv ----
`timescale 1ns/100ps
module sssl_top_assertions (
  // clock and reset
  input wire       core_clk_i,
  input wire       rst_n_i,
  // link pins
  input wire       serial_data_in_i,
  input wire       shift_clock_i,
  input wire       storage_clock_i,
  input wire       master_reset_n_i,
  input wire       out_enable_n_i,
  input wire       cascade_serial_out_o,
  // parallel side and status
  input wire [7:0] parallel_drive_out_o,
  input wire [7:0] parallel_drive_oe_o,
  input wire       event_ready_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_drive_level_low: assert property (parallel_drive_out_o == 8'h00) else $error("drive value not low");
  a_off_when_disabled: assert property (out_enable_n_i [*6] |-> parallel_drive_oe_o == 8'h00)
    else $error("outputs on while disabled");
  a_mreset_clears_chain: assert property (!master_reset_n_i [*5] |-> !cascade_serial_out_o)
    else $error("cascade kept under master reset");
  a_mreset_clears_out: assert property (!master_reset_n_i [*6] |-> parallel_drive_oe_o == 8'h00)
    else $error("outputs kept under master reset");
  a_cascade_holds_idle: assert property ((!$rose(shift_clock_i) && master_reset_n_i) [*8]
    |=> $stable(cascade_serial_out_o)) else $error("cascade moved without shift");
  a_store_holds_idle: assert property ((!$rose(storage_clock_i) && $stable(out_enable_n_i)
    && master_reset_n_i) [*8] |=> $stable(parallel_drive_oe_o)) else $error("outputs moved without store");
  a_clear_after_reset: assert property ($rose(rst_n_i) |-> !cascade_serial_out_o
    && parallel_drive_oe_o == 8'h00) else $error("outputs not clear after reset");
  a_ready_while_running: assert property ($past(rst_n_i) |-> event_ready_o) else $error("buffer refused");
endmodule
bind sssl_top sssl_top_assertions u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .serial_data_in_i(serial_data_in_i), .shift_clock_i(shift_clock_i), .storage_clock_i(storage_clock_i),
  .master_reset_n_i(master_reset_n_i), .out_enable_n_i(out_enable_n_i), .cascade_serial_out_o(cascade_serial_out_o),
  .parallel_drive_out_o(parallel_drive_out_o), .parallel_drive_oe_o(parallel_drive_oe_o), .event_ready_o(event_ready_o));

// ---- bench/sssl_link_model.sv ----
`timescale 1ns/100ps
module sssl_link_model (
  // link pins
  output reg data_o,
  output reg shclk_o,
  output reg stclk_o
);
  initial begin
    data_o = 1'b0;
    shclk_o = 1'b0;
    stclk_o = 1'b0;
  end
  // one 80 ns link period, data set half a period before the edge
  task pulse(input d, input sh, input st);
    begin
      data_o = d;
      #40;
      shclk_o = sh;
      stclk_o = st;
      #40;
      shclk_o = 1'b0;
      stclk_o = 1'b0;
    end
  endtask
endmodule

// ---- bench/sssl_top_tb.sv ----
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module sssl_top_tb;
  reg       core_clk_i = 1'b0;
  reg       rst_n_i = 1'b0;
  reg       mrst_n = 1'b1;
  reg       oe_n = 1'b0;
  wire      sdata, shclk, stclk, casc, rdy;
  wire [7:0] pout, poe;
  reg [7:0] sh, st, b;
  integer   err_count = 0, compares = 0, i, k;
  always #2 core_clk_i = ~core_clk_i;
  sssl_link_model lm (.data_o(sdata), .shclk_o(shclk), .stclk_o(stclk));
  sssl_top DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .serial_data_in_i(sdata), .shift_clock_i(shclk),
    .storage_clock_i(stclk), .master_reset_n_i(mrst_n), .out_enable_n_i(oe_n), .cascade_serial_out_o(casc),
    .parallel_drive_out_o(pout), .parallel_drive_oe_o(poe), .event_ready_o(rdy));
  function [7:0] exp_oe(input [7:0] s, input en_n);
    exp_oe = en_n ? 8'h00 : s;
  endfunction
  task give_verdict;
    begin
      if (err_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task idle;
    begin
      repeat (10) @(posedge core_clk_i);
      #1;
    end
  endtask
  initial begin
    #100000;
    err_count++;
    give_verdict;
  end
  initial begin
    k = $urandom(53);
    sh = 8'h00;
    st = 8'h00;
    repeat (20) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    for (i = 0; i < 40; i++) begin
      b = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : $urandom;
      for (k = 7; k >= 0; k--) begin
        // odd passes tie both clocks together
        if (i % 2 == 1) st = sh;
        sh = {sh[6:0], b[k]};
        lm.pulse(b[k], 1'b1, i % 2 == 1);
        `CHK("cascade", sh[7], casc)
      end
      if (i % 2 == 0) begin
        st = sh;
        lm.pulse(sdata, 1'b0, 1'b1);
      end
      `CHK("oe", exp_oe(st, oe_n), poe)
      `CHK("drive", 8'h00, pout)
      `CHK("ready", 1'b1, rdy)
      if (i % 8 == 4) begin
        oe_n = 1'b1;
        idle;
        `CHK("oe off", exp_oe(st, oe_n), poe)
        oe_n = 1'b0;
        idle;
        `CHK("oe back", exp_oe(st, oe_n), poe)
        `CHK("cascade kept", sh[7], casc)
      end
      if (i % 8 == 7) begin
        mrst_n = 1'b0;
        sh = 8'h00;
        st = 8'h00;
        idle;
        `CHK("cascade clear", sh[7], casc)
        `CHK("oe clear", exp_oe(st, oe_n), poe)
        mrst_n = 1'b1;
        idle;
      end
    end
    give_verdict;
  end
endmodule
